// ==== design/eac_defs.svh ====
// Constants for the exposure and readout control block
// Summary of operation
// (R1) Level mode: exposure runs only while the trigger input is low.
// (R2) Level mode: trigger rising edge starts readout of the exposed frame.
// (R3) Level mode: exposure lasts from trigger fall to the next rise.
// (R4) Programmable mode: trigger rising edge starts exposure.
// (R5) Programmable mode: readout starts when the preset exposure time ends.
// (R6) Programmable mode: trigger falling edges are ignored.
// (R7) Programmable exposure length comes from the timer one setting.
// (R8) One frame per trigger; periodic or irregular triggers are accepted.
// (R9) Free-run: internal control signal drives exposure, frames repeat forever.
// (R10) Pixels 1-502 go to the left path, 503-1004 to the right.
// (R11) Left path emits ascending, right path descending from the last pixel.
// (R12) Horizontal shifting runs at a 40 MHz average rate.
// (R13) Every sample from both paths is a 10 bit value.
// (R14) Samples are reordered so pixels leave in strictly ascending order.
// (R15) Lines are sent one after another until the frame is complete.
// (R16) Software selecting programmable mode must also set timer one.
// (R17) Gain and offset are software-settable values.
// (R18) Status indicator shows power present and a detected error.
// (R19) Exposure-active output is high exactly while an exposure runs.
// (R20) Line valid low time is 8.0 us, once 15.5 us after mid-frame start.
// (R21) Mode selects one of level, programmable, free-run; free-run ignores trigger.
// (R22) No new readout until the frame transfer ends; one request is held.
`ifndef EAC_DEFS_SVH
`define EAC_DEFS_SVH
`define EAC_ADDR_W 8
`define EAC_REG_CTRL 8'h00
`define EAC_REG_TIMER1 8'h04
`define EAC_REG_TIMER2 8'h08
`define EAC_REG_GAIN 8'h0C
`define EAC_REG_OFFSET 8'h10
`define EAC_REG_STATUS 8'h14
`define EAC_ST_EXPO 0
`define EAC_ST_FV 1
`define EAC_ST_PEND 2
`define EAC_ST_ERR 3
`define EAC_ST_RDST 5:4
`define EAC_GAIN_W 8
`define EAC_OFFSET_W 8
`define EAC_MODE_RST 2'h0
`define EAC_TIMER1_RST 32'h00000514
`define EAC_TIMER2_RST 32'h00000DAC
`define EAC_GAIN_RST 8'h00
`define EAC_OFFSET_RST 8'h00
`define EAC_RESP_OKAY 2'h0
`define EAC_RESP_SLVERR 2'h2
`define EAC_SAMPLE_W 10
`define EAC_PIX_PER_LINE 1004
`define EAC_LINES 1004
`define EAC_CLK_MHZ 100
`define EAC_HSHIFT_MHZ 40
`define EAC_CLK_NS 10
`define EAC_LV_GAP_NS 8000
`define EAC_LV_GAP_EXT_NS 15500
`define EAC_LV_GAP_CYC ((`EAC_LV_GAP_NS + `EAC_CLK_NS - 1) / `EAC_CLK_NS)
`define EAC_LV_GAP_EXT_CYC ((`EAC_LV_GAP_EXT_NS + `EAC_CLK_NS - 1) / `EAC_CLK_NS)
`endif

// ==== design/eac_line_buf.sv ====
// Two-bank line buffer that puts both readout halves into pixel order
`timescale 1ns/1ps
module eac_line_buf #(
   parameter int PIX = 1004,
   parameter int SW = 10,
   parameter int IW = $clog2(PIX)
) (
   input wire logic clk, // Clock
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic wr_en, // One horizontal shift step
   input wire logic wr_bank, // Bank being filled
   input wire logic [IW-1:0] wr_idx, // Shift step within the half line
   input wire logic [SW-1:0] left_d, // Left path sample
   input wire logic [SW-1:0] right_d, // Right path sample
   input wire logic rd_bank, // Bank being sent
   input wire logic [IW-1:0] rd_idx, // Pixel index to send
   output logic [SW-1:0] rd_data // Pixel one cycle after rd_idx
);
   localparam int AW = $clog2(2 * PIX);
   logic [SW-1:0] mem [0:2*PIX-1];
   logic [SW-1:0] rd_data_ff;
   logic [AW-1:0] wa_left;
   logic [AW-1:0] wa_right;
   logic [AW-1:0] ra;
   // Left half shifts out first pixel first, right half last pixel first
   assign wa_left = AW'(int'(wr_bank) * PIX + int'(wr_idx)); // [R10] [R11]
   assign wa_right = AW'(int'(wr_bank) * PIX + PIX - 1 - int'(wr_idx)); // [R10] [R11]
   assign ra = AW'(int'(rd_bank) * PIX + int'(rd_idx));
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wa_left] <= left_d;
         mem[wa_right] <= right_d;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rd_data_ff <= '0;
      end else begin
         rd_data_ff <= mem[ra]; // [R14]
      end
   end
   assign rd_data = rd_data_ff;
endmodule : eac_line_buf

// ==== design/eac_pkg.sv ====
// Types and helpers for the exposure and readout control block
package eac_pkg;
   typedef enum logic [1:0] {
      EAC_MODE_LEVEL = 2'b00,
      EAC_MODE_PROG = 2'b01,
      EAC_MODE_FREE = 2'b10
   } eac_mode_t;
   typedef enum logic [1:0] {
      EAC_RD_IDLE = 2'b00,
      EAC_RD_FIRST = 2'b01,
      EAC_RD_OUT = 2'b10,
      EAC_RD_GAP = 2'b11
   } eac_rd_state_t;
   function automatic logic [31:0] eac_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                             input logic [3:0] strb);
      logic [31:0] res;
      res = old_w;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_w[i*8 +: 8];
         end
      end
      return res;
   endfunction : eac_merge
endpackage : eac_pkg

// ==== design/eac_sync2.sv ====
// Two-stage synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
module eac_sync2 #(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic clk, // Sampling clock
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic d, // Asynchronous level
   output logic q // Synchronised level
);
   logic meta_ff;
   logic q_ff;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_ff <= RST_VAL;
         q_ff <= RST_VAL;
      end else begin
         meta_ff <= d;
         q_ff <= meta_ff;
      end
   end
   assign q = q_ff;
endmodule : eac_sync2

// ==== design/eac_top.sv ====
// Exposure control, readout sequencing and AXI4-Lite registers
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "eac_defs.svh"
module eac_top #(
   parameter int LINES = `EAC_LINES,
   parameter int PIX = `EAC_PIX_PER_LINE,
   parameter int SW = `EAC_SAMPLE_W
) (
   input wire logic aclk, // 100 MHz clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic [`EAC_ADDR_W-1:0] awaddr, // Write address
   input wire logic awvalid, // Write address valid
   output logic awready, // Write address ready
   input wire logic [31:0] wdata, // Write data
   input wire logic [3:0] wstrb, // Write byte lanes
   input wire logic wvalid, // Write data valid
   output logic wready, // Write data ready
   output logic [1:0] bresp, // Write response
   output logic bvalid, // Write response valid
   input wire logic bready, // Write response ready
   input wire logic [`EAC_ADDR_W-1:0] araddr, // Read address
   input wire logic arvalid, // Read address valid
   output logic arready, // Read address ready
   output logic [31:0] rdata, // Read data
   output logic [1:0] rresp, // Read response
   output logic rvalid, // Read data valid
   input wire logic rready, // Read data ready
   input wire logic ext_trigger, // External sync trigger pin
   input wire logic [SW-1:0] left_sample_in, // Digitised left path sample
   input wire logic [SW-1:0] right_sample_in, // Digitised right path sample
   output logic line_load, // Move next line into the shift paths
   output logic h_shift, // Horizontal shift step
   output logic [`EAC_GAIN_W-1:0] variable_gain_stage, // Gain setting
   output logic [`EAC_OFFSET_W-1:0] adc_offset, // Offset setting
   output logic exposure_active_out, // High during exposure
   output logic frame_valid, // Frame being sent
   output logic line_valid, // Line being sent
   output logic [SW-1:0] pixel_data, // Pixel value
   output logic led_power, // Power present indicator
   output logic led_error // Error indicator
);
   import eac_pkg::*;
   localparam int HALF = PIX / 2;
   localparam int IW = $clog2(PIX);
   localparam int LW = $clog2(LINES + 1);
   localparam int GAP_N = `EAC_LV_GAP_CYC;
   localparam int EXT_N = `EAC_LV_GAP_EXT_CYC;
   localparam logic [10:0] GAP_C = 11'(GAP_N - 1);
   localparam logic [10:0] EXT_C = 11'(EXT_N - 1);
   localparam logic [7:0] HS_STEP = 8'(`EAC_HSHIFT_MHZ);
   localparam logic [7:0] HS_WRAP = 8'(`EAC_CLK_MHZ);
   if (PIX % 2 != 0 || PIX < 4 || LINES < 1 || SW != `EAC_SAMPLE_W) begin : g_bad_cfg
      $error("eac_top: unsupported line or sample geometry");
   end

   logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [31:0] rdata_ff, rd_mux, timer1_ff, timer2_ff, cnt_ff;
   logic rd_err, wr_err, wr_do, rd_do, err_clr;
   eac_mode_t mode_ff, mode_prev_ff;
   logic [`EAC_GAIN_W-1:0] gain_ff;
   logic [`EAC_OFFSET_W-1:0] offset_ff;
   logic trig_s, trig_d_ff, trig_rise, trig_fall, mode_chg;
   logic expo_ff, fr_high_ff, expo_start, expo_end;
   logic pend_ff, err_ff, ext_gap_ff, led_power_ff;
   eac_rd_state_t st_ff;
   logic [IW-1:0] pix_ff, shift_idx_ff;
   logic [LW-1:0] line_cnt_ff;
   logic [10:0] gap_ff;
   logic fv_ff, lv_ff, rd_bank_ff, rd_take, go_out, shift_start, shift_last;
   logic shift_busy_ff, shift_bank_ff, line_load_ff, h_shift_ff;
   logic [7:0] hs_acc_ff, hs_sum;
   logic hs_hit;

   // Register bus: address and data are taken together, one answer outstanding
   assign wr_do = awvalid && awready_ff && wvalid && wready_ff;
   assign rd_do = arvalid && arready_ff;
   assign wr_err = !(awaddr inside {`EAC_REG_CTRL, `EAC_REG_TIMER1, `EAC_REG_TIMER2,
                                    `EAC_REG_GAIN, `EAC_REG_OFFSET, `EAC_REG_STATUS});
   assign err_clr = wr_do && awaddr == `EAC_REG_STATUS && wstrb[0] && wdata[`EAC_ST_ERR];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= `EAC_RESP_OKAY;
      end else begin
         awready_ff <= awvalid && wvalid && !awready_ff && !bvalid_ff;
         wready_ff <= awvalid && wvalid && !awready_ff && !bvalid_ff;
         if (wr_do) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_err ? `EAC_RESP_SLVERR : `EAC_RESP_OKAY;
         end else if (bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   always_comb begin
      rd_mux = '0;
      rd_err = 1'b0;
      case (araddr)
         `EAC_REG_CTRL: rd_mux[1:0] = mode_ff;
         `EAC_REG_TIMER1: rd_mux = timer1_ff;
         `EAC_REG_TIMER2: rd_mux = timer2_ff;
         `EAC_REG_GAIN: rd_mux[`EAC_GAIN_W-1:0] = gain_ff;
         `EAC_REG_OFFSET: rd_mux[`EAC_OFFSET_W-1:0] = offset_ff;
         `EAC_REG_STATUS: begin
            rd_mux[`EAC_ST_EXPO] = expo_ff;
            rd_mux[`EAC_ST_FV] = fv_ff;
            rd_mux[`EAC_ST_PEND] = pend_ff;
            rd_mux[`EAC_ST_ERR] = err_ff;
            rd_mux[`EAC_ST_RDST] = st_ff;
         end
         default: rd_err = 1'b1;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rdata_ff <= '0;
         rresp_ff <= `EAC_RESP_OKAY;
      end else begin
         arready_ff <= arvalid && !arready_ff && !rvalid_ff;
         if (rd_do) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_mux;
            rresp_ff <= rd_err ? `EAC_RESP_SLVERR : `EAC_RESP_OKAY;
         end else if (rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   // Settings; the reserved mode code is refused so one mode is always in force
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_ff <= eac_mode_t'(`EAC_MODE_RST);
         timer1_ff <= `EAC_TIMER1_RST;
         timer2_ff <= `EAC_TIMER2_RST;
         gain_ff <= `EAC_GAIN_RST;
         offset_ff <= `EAC_OFFSET_RST;
      end else if (wr_do) begin
         case (awaddr)
            `EAC_REG_CTRL: begin
               if (wstrb[0] && wdata[1:0] != 2'b11) begin
                  mode_ff <= eac_mode_t'(wdata[1:0]); // [R21]
               end
            end
            `EAC_REG_TIMER1: timer1_ff <= eac_merge(timer1_ff, wdata, wstrb); // [R7] [R16]
            `EAC_REG_TIMER2: timer2_ff <= eac_merge(timer2_ff, wdata, wstrb);
            `EAC_REG_GAIN: if (wstrb[0]) gain_ff <= wdata[`EAC_GAIN_W-1:0]; // [R17]
            `EAC_REG_OFFSET: if (wstrb[0]) offset_ff <= wdata[`EAC_OFFSET_W-1:0]; // [R17]
            default: ;
         endcase
      end
   end

   // Trigger pin crosses in; idle high so reset cannot look like a rise
   eac_sync2 #(.RST_VAL(1'b1)) u_trig_sync (
      .clk(aclk),
      .rst_n(aresetn),
      .d(ext_trigger),
      .q(trig_s)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trig_d_ff <= 1'b1;
         mode_prev_ff <= eac_mode_t'(`EAC_MODE_RST);
      end else begin
         trig_d_ff <= trig_s;
         mode_prev_ff <= mode_ff;
      end
   end
   assign trig_rise = trig_s && !trig_d_ff;
   assign trig_fall = !trig_s && trig_d_ff;
   assign mode_chg = mode_ff != mode_prev_ff;

   // Free-run ignores the trigger entirely; falls mean nothing in programmable
   always_comb begin
      expo_start = 1'b0;
      expo_end = 1'b0;
      if (!mode_chg) begin
         case (mode_ff)
            EAC_MODE_LEVEL: begin
               expo_start = trig_fall && !expo_ff; // [R1] [R3]
               expo_end = trig_rise && expo_ff; // [R2] [R3]
            end
            EAC_MODE_PROG: begin
               expo_start = trig_rise && !expo_ff; // [R4] [R6]
               expo_end = expo_ff && cnt_ff <= 32'h00000001; // [R5]
            end
            EAC_MODE_FREE: begin
               expo_start = !expo_ff && !fr_high_ff; // [R9] [R21]
               expo_end = expo_ff && cnt_ff <= 32'h00000001; // [R9]
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         expo_ff <= 1'b0;
         fr_high_ff <= 1'b0;
         cnt_ff <= '0;
      end else if (mode_chg) begin
         expo_ff <= 1'b0;
         fr_high_ff <= 1'b0;
      end else if (expo_start) begin
         expo_ff <= 1'b1; // [R19]
         cnt_ff <= timer1_ff; // [R7]
      end else if (expo_end) begin
         expo_ff <= 1'b0; // [R19]
         fr_high_ff <= mode_ff == EAC_MODE_FREE;
         cnt_ff <= timer2_ff;
      end else if (fr_high_ff && cnt_ff <= 32'h00000001) begin
         fr_high_ff <= 1'b0;
      end else if ((expo_ff && mode_ff != EAC_MODE_LEVEL) || fr_high_ff) begin
         cnt_ff <= cnt_ff - 32'h00000001;
      end
   end

   // A new request beats the take in the same cycle; a second one is an overrun
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend_ff <= 1'b0;
         err_ff <= 1'b0;
         ext_gap_ff <= 1'b0;
         led_power_ff <= 1'b0;
      end else begin
         pend_ff <= expo_end || (pend_ff && !rd_take); // [R8] [R22]
         err_ff <= (expo_end && pend_ff && !rd_take) || (err_ff && !err_clr); // [R18]
         // Dropped at frame end so a stale request cannot stretch the next frame
         ext_gap_ff <= (expo_start && fv_ff) || (ext_gap_ff && fv_ff && !(gap_ff == EXT_C
                       && st_ff == EAC_RD_GAP)); // [R20]
         led_power_ff <= 1'b1; // [R18]
      end
   end

   // Readout: one line shifts into a bank while the other bank is sent
   // Queued request waits for frame valid to drop so frames stay apart
   assign rd_take = st_ff == EAC_RD_IDLE && pend_ff && !fv_ff; // [R22]
   assign go_out = !shift_busy_ff && (st_ff == EAC_RD_FIRST
                   || (st_ff == EAC_RD_GAP && gap_ff == 11'h000));
   assign shift_start = rd_take || (go_out && int'(line_cnt_ff) < LINES - 1);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= EAC_RD_IDLE;
         pix_ff <= '0;
         line_cnt_ff <= '0;
         gap_ff <= '0;
         rd_bank_ff <= 1'b0;
      end else begin
         case (st_ff)
            EAC_RD_IDLE: begin
               if (rd_take) begin
                  st_ff <= EAC_RD_FIRST;
                  line_cnt_ff <= '0;
               end
            end
            EAC_RD_FIRST: begin
               if (go_out) begin
                  st_ff <= EAC_RD_OUT;
                  pix_ff <= '0;
                  rd_bank_ff <= shift_bank_ff;
               end
            end
            EAC_RD_OUT: begin
               pix_ff <= pix_ff + 1'b1; // [R14]
               if (int'(pix_ff) == PIX - 1) begin
                  if (int'(line_cnt_ff) == LINES - 1) begin
                     st_ff <= EAC_RD_IDLE;
                  end else begin
                     st_ff <= EAC_RD_GAP; // [R15]
                     gap_ff <= ext_gap_ff ? EXT_C : GAP_C; // [R20]
                     line_cnt_ff <= line_cnt_ff + 1'b1;
                  end
               end
            end
            EAC_RD_GAP: begin
               if (gap_ff != 11'h000) begin
                  gap_ff <= gap_ff - 11'h001;
               end else if (go_out) begin
                  st_ff <= EAC_RD_OUT;
                  pix_ff <= '0;
                  rd_bank_ff <= shift_bank_ff;
               end
            end
            default: st_ff <= EAC_RD_IDLE;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fv_ff <= 1'b0;
         lv_ff <= 1'b0;
      end else begin
         fv_ff <= st_ff != EAC_RD_IDLE || rd_take;
         lv_ff <= st_ff == EAC_RD_OUT; // Aligned with the buffer's read latency
      end
   end

   // 40 of every 100 clocks carry a shift step
   assign hs_sum = hs_acc_ff + HS_STEP;
   assign hs_hit = hs_sum >= HS_WRAP;
   assign shift_last = h_shift_ff && int'(shift_idx_ff) == HALF - 1;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hs_acc_ff <= '0;
         h_shift_ff <= 1'b0;
         shift_busy_ff <= 1'b0;
         shift_idx_ff <= '0;
         shift_bank_ff <= 1'b1;
         line_load_ff <= 1'b0;
      end else begin
         hs_acc_ff <= hs_hit ? hs_sum - HS_WRAP : hs_sum; // [R12]
         h_shift_ff <= shift_busy_ff && hs_hit && !shift_last; // [R12]
         line_load_ff <= shift_start;
         if (shift_start) begin
            shift_busy_ff <= 1'b1;
            shift_idx_ff <= '0;
            shift_bank_ff <= !shift_bank_ff;
         end else if (shift_last) begin
            shift_busy_ff <= 1'b0;
         end else if (h_shift_ff) begin
            shift_idx_ff <= shift_idx_ff + 1'b1;
         end
      end
   end

   // Samples arrive with the shift step that moved them
   eac_line_buf #(.PIX(PIX), .SW(SW), .IW(IW)) u_line_buf (
      .clk(aclk),
      .rst_n(aresetn),
      .wr_en(h_shift_ff), // [R13]
      .wr_bank(shift_bank_ff),
      .wr_idx(shift_idx_ff),
      .left_d(left_sample_in),
      .right_d(right_sample_in),
      .rd_bank(rd_bank_ff),
      .rd_idx(pix_ff),
      .rd_data(pixel_data)
   );

   assign awready = awready_ff;
   assign wready = wready_ff;
   assign bvalid = bvalid_ff;
   assign bresp = bresp_ff;
   assign arready = arready_ff;
   assign rvalid = rvalid_ff;
   assign rdata = rdata_ff;
   assign rresp = rresp_ff;
   assign line_load = line_load_ff;
   assign h_shift = h_shift_ff;
   assign variable_gain_stage = gain_ff;
   assign adc_offset = offset_ff;
   assign exposure_active_out = expo_ff;
   assign frame_valid = fv_ff;
   assign line_valid = lv_ff;
   assign led_power = led_power_ff;
   assign led_error = err_ff;

   // Checks
   logic seen_ff;
   logic [11:0] low_cnt_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn || !fv_ff) begin
         seen_ff <= 1'b0;
         low_cnt_ff <= '0;
      end else if (lv_ff) begin
         seen_ff <= 1'b1;
         low_cnt_ff <= '0;
      end else if (low_cnt_ff != 12'hFFF) begin
         low_cnt_ff <= low_cnt_ff + 12'h001;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_fr_low;
      mode_ff == EAC_MODE_FREE && !mode_chg && !expo_ff && !fr_high_ff;
   endsequence
   sequence s_frame_open;
      st_ff == EAC_RD_FIRST && fv_ff && line_load_ff;
   endsequence

   property p_lvl_start;
      mode_ff == EAC_MODE_LEVEL && !mode_chg && trig_fall && !expo_ff |=> expo_ff;
   endproperty
   a_lvl_start: assert property (p_lvl_start) else $error("level fall did not expose"); // [R1]
   property p_lvl_read;
      mode_ff == EAC_MODE_LEVEL && !mode_chg && trig_rise && expo_ff |=> !expo_ff && pend_ff;
   endproperty
   a_lvl_read: assert property (p_lvl_read) else $error("level rise did not end"); // [R2]
   property p_prog_start;
      mode_ff == EAC_MODE_PROG && !mode_chg && trig_rise && !expo_ff
         |=> expo_ff && cnt_ff == $past(timer1_ff);
   endproperty
   a_prog_start: assert property (p_prog_start) else $error("prog start wrong"); // [R4]
   property p_prog_end;
      mode_ff == EAC_MODE_PROG && !mode_chg && expo_ff && cnt_ff == 32'h00000001
         |=> !expo_ff && pend_ff;
   endproperty
   a_prog_end: assert property (p_prog_end) else $error("prog exposure overran"); // [R5]
   property p_prog_fall;
      mode_ff == EAC_MODE_PROG && !mode_chg && trig_fall && !expo_ff |=> !expo_ff;
   endproperty
   a_prog_fall: assert property (p_prog_fall) else $error("prog fall acted"); // [R6]
   property p_free;
      s_fr_low |=> expo_ff && cnt_ff == $past(timer1_ff);
   endproperty
   a_free: assert property (p_free) else $error("free-run did not expose"); // [R9]
   property p_shift_rate;
      h_shift_ff |=> !h_shift_ff ##1 !h_shift_ff or !h_shift_ff;
   endproperty
   a_shift_rate: assert property (p_shift_rate) else $error("shift too fast"); // [R12]
   property p_gap;
      $rose(lv_ff) && seen_ff |-> int'(low_cnt_ff) == GAP_N || int'(low_cnt_ff) == EXT_N;
   endproperty
   a_gap: assert property (p_gap) else $error("line gap wrong"); // [R20]
   property p_take;
      rd_take |=> s_frame_open;
   endproperty
   a_take: assert property (p_take) else $error("readout not started"); // [R22]
   property p_order;
      st_ff == EAC_RD_OUT && pix_ff != '0 |-> pix_ff == $past(pix_ff) + 1'b1;
   endproperty
   a_order: assert property (p_order) else $error("pixel order broken"); // [R14]
endmodule : eac_top

// ==== verif/eac_grabber.sv ====
// Frame grabber side model: sample source for both readout halves
`timescale 1ns/1ps
module eac_grabber #(
   parameter int PIX = 8
) (
   input wire logic clk, // Clock
   input wire logic line_load, // New line enters paths
   input wire logic h_shift, // Shift step
   output logic [9:0] left_s, // Left path sample
   output logic [9:0] right_s // Right path sample
);
   int k = 0;
   always @(posedge clk) begin
      if (line_load) k <= 0;
      else if (h_shift) k <= k + 1;
   end
   // Each sample carries its own pixel number so order errors show
   assign left_s = 10'(k + 1);
   assign right_s = 10'(PIX - k);
endmodule : eac_grabber

// ==== verif/tb.sv ====
// Self-checking bench for the exposure and readout control block
`timescale 1ns/1ps
`include "eac_defs.svh"
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin error_cnt++; \
   $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module tb;
   localparam int PIX = 8;
   localparam int LN = 2;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic ext_trigger = 1, line_load, h_shift, exposure_active_out, frame_valid, line_valid;
   logic awready, wready, bvalid, arready, rvalid, led_power, led_error;
   logic [7:0] awaddr = 0, araddr = 0, variable_gain_stage, adc_offset;
   logic [31:0] wdata = 0, rdata, rd;
   logic [3:0] wstrb = 0;
   logic [1:0] bresp, rresp, rr, br;
   logic [9:0] left_s, right_s, pixel_data;
   int error_cnt = 0, samples_checked = 0, n;
   always #5 aclk = ~aclk;
   eac_top #(.LINES(LN), .PIX(PIX)) u_eac_top (.aclk, .aresetn, .awaddr, .awvalid, .awready,
      .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
      .rdata, .rresp, .rvalid, .rready, .ext_trigger, .left_sample_in(left_s),
      .right_sample_in(right_s), .line_load, .h_shift, .variable_gain_stage, .adc_offset,
      .exposure_active_out, .frame_valid, .line_valid, .pixel_data, .led_power, .led_error);
   eac_grabber #(.PIX(PIX)) u_eac_grabber (.clk(aclk), .line_load, .h_shift, .left_s, .right_s);
   task close_out;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : close_out
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_ok, w_ok;
      aw_ok = 0;
      w_ok = 0;
      @(posedge aclk);
      awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1; wvalid <= 1; bready <= 1;
      do begin
         @(posedge aclk);
         if (awready && !aw_ok) begin aw_ok = 1; awvalid <= 0; end
         if (wready && !w_ok) begin w_ok = 1; wvalid <= 0; end
      end while (!(aw_ok && w_ok));
      do @(posedge aclk); while (!bvalid);
      br = bresp; bready <= 0;
   endtask : wr
   task rdr(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a; arvalid <= 1; rready <= 1;
      do @(posedge aclk); while (!arready);
      arvalid <= 0;
      do @(posedge aclk); while (!rvalid);
      rd = rdata; rr = rresp; rready <= 0;
   endtask : rdr
   task cyc(input int c);
      repeat (c) @(posedge aclk);
   endtask : cyc
   task frame_chk;
      for (int l = 0; l < LN; l++) begin
         n = 0;
         while (!line_valid && n < 4000) begin @(negedge aclk); n++; end
         for (int i = 0; i < PIX; i++) begin
            `CHK("pixel", 10'(i + 1), pixel_data)
            @(negedge aclk);
         end
         `CHK("line_end", 1'b0, line_valid)
      end
      `CHK("frame_end", 1'b0, frame_valid)
   endtask : frame_chk
   task t_regs;
      rdr(`EAC_REG_TIMER1);
      `CHK("timer1", `EAC_TIMER1_RST, rd)
      rdr(8'hFC);
      `CHK("unmapped", `EAC_RESP_SLVERR, rr)
      wr(`EAC_REG_GAIN, 32'h0000005A);
      `CHK("wr_resp", `EAC_RESP_OKAY, br)
      wr(`EAC_REG_OFFSET, 32'h000000A5);
      wr(`EAC_REG_CTRL, 32'h00000003);
      rdr(`EAC_REG_CTRL);
      `CHK("mode_keep", 32'h00000000, rd)
      wr(8'hF8, 32'h00000000);
      `CHK("wr_unmapped", `EAC_RESP_SLVERR, br)
      cyc(2);
      `CHK("gain", 8'h5A, variable_gain_stage)
      `CHK("offset", 8'hA5, adc_offset)
      `CHK("power", 1'b1, led_power)
      $display("test regs done");
   endtask : t_regs
   task t_level;
      ext_trigger <= 0;
      cyc(40);
      `CHK("lvl_expo", 1'b1, exposure_active_out)
      ext_trigger <= 1;
      cyc(8);
      `CHK("lvl_end", 1'b0, exposure_active_out)
      frame_chk();
      $display("test level done");
   endtask : t_level
   task t_prog;
      wr(`EAC_REG_TIMER1, 32'h00000028);
      wr(`EAC_REG_CTRL, 32'h00000001);
      ext_trigger <= 0;
      cyc(10);
      `CHK("prog_fall", 1'b0, exposure_active_out)
      ext_trigger <= 1;
      n = 0;
      while (!exposure_active_out && n < 20) begin @(posedge aclk); n++; end
      n = 0;
      while (exposure_active_out && n < 200) begin @(posedge aclk); n++; end
      `CHK("prog_len", 40, n)
      frame_chk();
      $display("test prog done");
   endtask : t_prog
   task t_free;
      wr(`EAC_REG_TIMER2, 32'h00000014);
      wr(`EAC_REG_CTRL, 32'h00000002);
      cyc(5);
      `CHK("free_expo", 1'b1, exposure_active_out)
      n = 0;
      while (exposure_active_out && n < 200) begin @(posedge aclk); n++; end
      n = 0;
      while (!exposure_active_out && n < 200) begin @(posedge aclk); n++; end
      `CHK("free_low", 21, n)
      cyc(120);
      `CHK("overrun", 1'b1, led_error)
      wr(`EAC_REG_CTRL, 32'h00000000);
      wr(`EAC_REG_STATUS, 32'h00000008);
      `CHK("err_clear", 1'b0, led_error)
      n = 0;
      while (frame_valid && n < 3000) begin @(posedge aclk); n++; end
      `CHK("free_frame_end", 1'b0, frame_valid)
      cyc(2);
      `CHK("queued", 1'b1, frame_valid)
      $display("test free done");
   endtask : t_free
   initial begin
      cyc(6);
      aresetn <= 1;
      cyc(4);
      t_regs();
      t_level();
      t_prog();
      t_free();
      close_out();
   end
   initial begin
      #500000;
      error_cnt++;
      close_out();
   end
endmodule : tb
